// ===== logic/cbq_sequencer.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module cbq_sequencer
    import cbq_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdData,
    input  wire logic [15:0] sampleIn,
    input  wire logic        externalTriggerInput,
    output logic             bufferPulse,
    output logic             sweepStart,
    output logic             sweepRun,
    output logic      [1:0]  sweepKind,
    output logic             pointValid,
    input  wire logic        pointReady,
    output cbq_point_t       pointOut
);
    cbq_state_t  state_q;
    cbq_kind_t   kind_q;
    logic [3:0]  mode_q;
    logic        pulseType_q;
    logic        pulsePol_q;
    logic        fastMode_q;
    logic [19:0] interval_q;
    logic [15:0] curveLength_q;
    logic [3:0]  sweep_q;
    logic [11:0] pos_q;
    logic [15:0] count_q;
    logic [19:0] usCnt_q;
    logic [7:0]  tickCnt_q;
    logic [7:0]  pulseCnt_q;
    logic        trigMeta_q;
    logic        trigSync_q;
    logic        trigLast_q;
    logic        firstPoint_q;
    logic [31:0] rdData_q;
    logic        fifoInReady;
    cbq_point_t  fifoOut;

    logic        rise;
    logic        fall;
    logic        cmdWr;
    logic [2:0]  cmd;
    logic        linked;
    logic        perPoint;
    logic        startEdge;
    logic        stopEdge;
    logic        intervalTick;
    logic        store;
    logic        full;
    logic        stopNow;
    logic        beginRun;
    logic        armTrig;

    function automatic logic isLinked(input logic [3:0] s);
        return (s == SWEEP_LINK_F) || (s == SWEEP_LINK_A) || (s == SWEEP_LINK_FA);
    endfunction

    function automatic logic isPerPointMode(input logic [3:0] m);
        return m[0] && (m < 4'h8);
    endfunction

    function automatic logic [19:0] clampInterval(input logic [19:0] v, input logic fast);
        logic [19:0] lo;
        lo = fast ? MIN_FAST_US : MIN_STD_US;
        return (v < lo) ? lo : v;
    endfunction

    // External trigger: two flops, then edge detect on the second only
    always_ff @(posedge mclk) begin
        if (rst) begin
            trigMeta_q <= 1'b0;
            trigSync_q <= 1'b0;
            trigLast_q <= 1'b0;
        end else begin
            trigMeta_q <= externalTriggerInput;
            trigSync_q <= trigMeta_q;
            trigLast_q <= trigSync_q;
        end
    end

    assign rise = trigSync_q && !trigLast_q;
    assign fall = !trigSync_q && trigLast_q;

    assign cmdWr    = regWrite && (regAddr == REG_CTRL);
    assign cmd      = regWrData[2:0];
    assign linked   = isLinked(sweep_q);
    assign perPoint = (kind_q == CBQ_KIND_EXTERNAL_TRIGGER_INPUT) && isPerPointMode(mode_q);

    // Start edges for modes 0,4,8 rising and 2,6,9 falling
    assign startEdge = (mode_q == 4'h9) ? fall : (mode_q[1] ? fall : rise);

    // Stop edges: continuous 1/2, triggered 8/9
    always_comb begin
        stopEdge = 1'b0;
        unique case (kind_q)
            CBQ_KIND_CONT: begin
                if (mode_q == 4'h1) begin
                    stopEdge = rise;
                end else if (mode_q == 4'h2) begin
                    stopEdge = fall;
                end
            end
            CBQ_KIND_EXTERNAL_TRIGGER_INPUT: begin
                if (mode_q == 4'h8) begin
                    stopEdge = fall;
                end else if (mode_q == 4'h9) begin
                    stopEdge = rise;
                end
            end
            default: ;
        endcase
    end

    assign intervalTick = (usCnt_q == 20'h0_0001) && (tickCnt_q == 8'h0_0);
    // Per-point: sample on mode edge only; one store per detected edge
    // A full FIFO skips the tick: points are lost, never overwritten
    assign store = (state_q == CBQ_RUN) && fifoInReady &&
                   (perPoint ? (mode_q[1] ? fall : rise) : intervalTick);
    assign full  = (kind_q == CBQ_KIND_FULL) ? (pos_q == BUF_LAST)
                 : (count_q + 16'h0_001 >= curveLength_q);
    always_comb begin
        stopNow = 1'b0;
        if (state_q != CBQ_IDLE) begin
            if (cmdWr && cmd == CMD_HALT) begin
                stopNow = 1'b1;
            end else if (state_q == CBQ_RUN && stopEdge) begin
                stopNow = 1'b1;
            end else if (store && kind_q != CBQ_KIND_CONT && (kind_q == CBQ_KIND_FULL || mode_q < 4'h4)) begin
                stopNow = full;
            end
        end
    end

    assign armTrig  = (state_q == CBQ_ARMED) && startEdge;
    assign beginRun = (state_q == CBQ_IDLE) && cmdWr &&
                      (cmd == CMD_TO_FULL || cmd == CMD_CONT || cmd == CMD_CONT_NOPAR || cmd == CMD_EXTERNAL_TRIGGER_INPUT);

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= CBQ_IDLE;
            kind_q  <= CBQ_KIND_FULL;
        end else if (stopNow) begin
            state_q <= CBQ_IDLE;
        end else if (beginRun) begin
            unique case (cmd)
                CMD_TO_FULL: begin
                    kind_q  <= CBQ_KIND_FULL;
                    state_q <= CBQ_RUN;
                end
                CMD_CONT: begin
                    kind_q  <= CBQ_KIND_CONT;
                    state_q <= CBQ_RUN;
                end
                CMD_CONT_NOPAR: begin
                    kind_q  <= CBQ_KIND_EXTERNAL_TRIGGER_INPUT;
                    // Old mode is ignored: mode 0 waits for a rising start edge
                    state_q <= CBQ_ARMED;
                end
                default: begin
                    kind_q  <= CBQ_KIND_EXTERNAL_TRIGGER_INPUT;
                    // Modes 1,3,5,7 run at once and wait for sample edges
                    state_q <= isPerPointMode(mode_q) ? CBQ_RUN : CBQ_ARMED;
                end
            endcase
        end else if (armTrig) begin
            state_q <= CBQ_RUN;
        end
    end

    // Settings; sweep setting is locked while a linked run is active
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q        <= 4'h0;
            pulseType_q   <= 1'b0;
            pulsePol_q    <= 1'b0;
            fastMode_q    <= 1'b0;
            interval_q    <= INTERVAL_RST;
            curveLength_q <= LEN_RESET;
            sweep_q       <= 4'h0;
        end else if (beginRun && cmd == CMD_CONT_NOPAR) begin
            mode_q <= 4'h0;
        end else if (regWrite && state_q == CBQ_IDLE) begin
            unique case (regAddr)
                REG_MODE: begin
                    mode_q      <= regWrData[MODE_LSB +: 4];
                    pulseType_q <= regWrData[PTYPE_BIT];
                    pulsePol_q  <= regWrData[PPOL_BIT];
                    fastMode_q  <= regWrData[FAST_BIT];
                    // Leaving fast mode must not keep an interval under the standard minimum
                    interval_q  <= clampInterval(interval_q, regWrData[FAST_BIT]);
                end
                REG_INTERVAL: begin
                    interval_q <= clampInterval(regWrData[19:0], fastMode_q);
                end
                REG_LENGTH: begin
                    curveLength_q <= regWrData[15:0];
                end
                REG_SWEEP: begin
                    sweep_q <= regWrData[3:0];
                end
                default: ;
            endcase
        end
    end

    // Interval timer: microsecond prescaler and microsecond down-counter
    always_ff @(posedge mclk) begin
        if (rst || state_q != CBQ_RUN) begin
            tickCnt_q <= 8'(US_CYCLES - 1);
            usCnt_q   <= interval_q;
        end else if (tickCnt_q != 8'h0_0) begin
            tickCnt_q <= tickCnt_q - 8'h0_1;
        end else begin
            tickCnt_q <= 8'(US_CYCLES - 1);
            usCnt_q   <= (usCnt_q == 20'h0_0001) ? interval_q : usCnt_q - 20'h0_0001;
        end
    end

    // Write position persists across runs; continuous wraps
    always_ff @(posedge mclk) begin
        if (rst) begin
            pos_q   <= '0;
            count_q <= '0;
        end else begin
            if (beginRun) begin
                count_q <= '0;
            end else if (store) begin
                count_q <= count_q + 16'h0_001;
            end
            if (store) begin
                pos_q <= (pos_q == BUF_LAST) ? '0 : pos_q + 12'h0_01;
            end
        end
    end

    // Sweep start pulse and run level for linked full/triggered runs
    always_ff @(posedge mclk) begin
        if (rst) begin
            sweepStart <= 1'b0;
            sweepRun   <= 1'b0;
        end else begin
            sweepStart <= beginRun && !stopNow && linked && cmd != CMD_CONT;
            if (stopNow) begin
                sweepRun <= 1'b0;
            end else if (beginRun && linked && cmd != CMD_CONT) begin
                sweepRun <= 1'b1;
            end
        end
    end
    assign sweepKind = sweep_q[1:0];

    // Per-curve pulse keys on a flag: count_q wraps in long continuous runs
    always_ff @(posedge mclk) begin
        if (rst) begin
            firstPoint_q <= 1'b0;
        end else if (beginRun) begin
            firstPoint_q <= 1'b1;
        end else if (store) begin
            firstPoint_q <= 1'b0;
        end
    end

    // Output pulse: stretched so a slow receiver sees it
    always_ff @(posedge mclk) begin
        if (rst) begin
            pulseCnt_q <= 8'h0_0;
        end else if (store && (pulseType_q || firstPoint_q)) begin
            pulseCnt_q <= PULSE_CYCLES;
        end else if (pulseCnt_q != 8'h0_0) begin
            pulseCnt_q <= pulseCnt_q - 8'h0_1;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            bufferPulse <= 1'b0;
        end else begin
            bufferPulse <= (pulseCnt_q != 8'h0_0) ^ pulsePol_q;
        end
    end

    cbq_fifo #(
        .WIDTH ($bits(cbq_point_t)),
        .DEPTH (4)
    ) u_fifo (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (store),
        .inReady  (fifoInReady),
        .inData   ({pos_q, sampleIn}),
        .outValid (pointValid),
        .outReady (pointReady),
        .outData  (fifoOut)
    );
    assign pointOut = fifoOut;

    // Register read, data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData_q <= 32'h0000_0000;
        end else if (regRead) begin
            unique case (regAddr)
                REG_MODE: begin
                    rdData_q <= {25'h0, fastMode_q, pulsePol_q, pulseType_q, mode_q};
                end
                REG_INTERVAL: begin
                    rdData_q <= {12'h0, interval_q};
                end
                REG_LENGTH: begin
                    rdData_q <= {16'h0, curveLength_q};
                end
                REG_SWEEP: begin
                    rdData_q <= {28'h0, sweep_q};
                end
                REG_STATUS: begin
                    rdData_q <= {pos_q, count_q, kind_q, state_q};
                end
                REG_SAMPLE: begin
                    rdData_q <= {4'h0, fifoOut};
                end
                default: begin
                    rdData_q <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdData_q <= 32'h0000_0000;
        end
    end
    assign regRdData = rdData_q;
endmodule // cbq_sequencer

// ===== logic/cbq_pkg.sv
package cbq_pkg;

    // Register map over the plain register port
    localparam logic [3:0]  REG_CTRL      = 4'h0;  // write: command strobes
    localparam logic [3:0]  REG_MODE      = 4'h1;  // mode, pulse type, polarity
    localparam logic [3:0]  REG_INTERVAL  = 4'h2;  // storage interval in us
    localparam logic [3:0]  REG_LENGTH    = 4'h3;  // curve length in points
    localparam logic [3:0]  REG_SWEEP     = 4'h4;  // sweep setting
    localparam logic [3:0]  REG_STATUS    = 4'h5;  // run state, position, count
    localparam logic [3:0]  REG_SAMPLE    = 4'h6;  // buffered point read port

    // Command codes written to REG_CTRL bits [2:0]
    localparam logic [2:0]  CMD_TO_FULL   = 3'h1;
    localparam logic [2:0]  CMD_CONT      = 3'h2;
    localparam logic [2:0]  CMD_CONT_NOPAR = 3'h3;
    localparam logic [2:0]  CMD_EXTERNAL_TRIGGER_INPUT      = 3'h4;
    localparam logic [2:0]  CMD_HALT      = 3'h5;

    // REG_MODE fields
    localparam int          MODE_LSB      = 0;     // 4 bits
    localparam int          PTYPE_BIT     = 4;
    localparam int          PPOL_BIT      = 5;
    localparam int          FAST_BIT      = 6;

    // Sweep link codes
    localparam logic [3:0]  SWEEP_LINK_F  = 4'h9;
    localparam logic [3:0]  SWEEP_LINK_A  = 4'hA;
    localparam logic [3:0]  SWEEP_LINK_FA = 4'hB;

    // Buffer geometry
    localparam int          BUF_AW        = 12;
    localparam logic [11:0] BUF_LAST      = 12'hF_FF;
    localparam logic [15:0] LEN_RESET     = 16'h0_064;

    // Timing
    localparam int          CLK_MHZ       = 250;
    localparam int          US_CYCLES     = CLK_MHZ;   // 1 us at 250 MHz
    localparam logic [19:0] MIN_FAST_US   = 20'h0_0001;
    localparam logic [19:0] MIN_STD_US    = 20'h0_03E8; // 1000 us
    localparam logic [19:0] INTERVAL_RST  = 20'h0_03E8;
    localparam logic [7:0]  PULSE_CYCLES  = 8'h0_4;

    typedef enum logic [1:0] {
        CBQ_IDLE  = 2'b00,
        CBQ_ARMED = 2'b01,
        CBQ_RUN   = 2'b11
    } cbq_state_t;

    typedef enum logic [1:0] {
        CBQ_KIND_FULL = 2'b00,
        CBQ_KIND_CONT = 2'b01,
        CBQ_KIND_EXTERNAL_TRIGGER_INPUT = 2'b10
    } cbq_kind_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] data;
    } cbq_point_t;

endpackage

// ===== logic/cbq_fifo.sv
`timescale 1ns/10ps
module cbq_fifo
    import cbq_pkg::*;
#(
    parameter int WIDTH = 28,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // cbq_fifo

// ===== verif/cbq_far_end.sv
`timescale 1ns/10ps
module cbq_far_end
    import cbq_pkg::*;
#(
    parameter int EDGE_GAP = 40
) (
    input  wire logic       mclk,
    input  wire logic       stall,
    input  wire logic       pointValid,
    output logic            pointReady,
    input  wire cbq_point_t pointOut,
    output logic            externalTriggerInput
);
    cbq_point_t got[$];

    initial externalTriggerInput = 1'b0;
    // Consumer stalls only when the bench asks, to back up the FIFO
    assign pointReady = !stall;

    always @(posedge mclk) begin
        if (pointValid && pointReady) begin
            got.push_back(pointOut);
        end
    end

    // A real source is held under 1 kHz; the gap is shortened to keep runs short
    task automatic drive(input logic lvl);
        repeat (EDGE_GAP) @(posedge mclk);
        externalTriggerInput <= lvl;
        repeat (EDGE_GAP) @(posedge mclk);
    endtask
endmodule // cbq_far_end

// ===== verif/cbq_sequencer_sva.sv
`timescale 1ns/10ps
module cbq_sequencer_sva
    import cbq_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdData,
    input wire logic [15:0] sampleIn,
    input wire logic        externalTriggerInput,
    input wire logic        bufferPulse,
    input wire logic        sweepStart,
    input wire logic        sweepRun,
    input wire logic [1:0]  sweepKind,
    input wire logic        pointValid,
    input wire logic        pointReady,
    input wire cbq_point_t  pointOut
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_sweep_one_cycle: assert property (sweepStart |=> !sweepStart)
        else $error("sweep start longer than one cycle");
    chk_sweep_then_run: assert property (sweepStart |-> ##[0:1] sweepRun)
        else $error("sweep start without sweep run");
    chk_sweep_kind_set: assert property (sweepRun |-> sweepKind != 2'b00)
        else $error("running sweep reports no link kind");
    chk_sweep_kind_hold: assert property (sweepRun && $past(sweepRun) |-> $stable(sweepKind))
        else $error("sweep kind changed while running");
    chk_pulse_high_width: assert property ($rose(bufferPulse) |-> bufferPulse [*4])
        else $error("pulse high phase too short");
    chk_pulse_low_width: assert property ($fell(bufferPulse) |-> !bufferPulse [*4])
        else $error("pulse low phase too short");
    chk_point_hold: assert property (pointValid && !pointReady |=> pointValid && $stable(pointOut))
        else $error("point dropped or changed while stalled");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !sweepRun && !pointValid && regRdData == 32'h0000_0000)
        else $error("outputs active after reset");

    cover property (sweepStart);
    cover property (pointValid && !pointReady);
    cover property ($fell(bufferPulse));
endmodule // cbq_sequencer_sva

bind cbq_sequencer cbq_sequencer_sva u_sva (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .sampleIn(sampleIn),
    .externalTriggerInput(externalTriggerInput), .bufferPulse(bufferPulse), .sweepStart(sweepStart),
    .sweepRun(sweepRun), .sweepKind(sweepKind), .pointValid(pointValid), .pointReady(pointReady),
    .pointOut(pointOut));

// ===== verif/curve_buffer_acquisition_sequencer_tb.sv
`timescale 1ns/10ps
module curve_buffer_acquisition_sequencer_tb
    import cbq_pkg::*;
;
    typedef struct {logic [31:0] mode, iv, exp;} cbq_row_t;
    typedef struct {logic [2:0] cmd; logic [3:0] mode; logic [1:0] s0, s1, s2;} cbq_edge_t;
    logic        mclk, rst, regWrite, regRead, ext, bufferPulse, sweepStart, sweepRun;
    logic        pointValid, pointReady, stall, pulsePrev;
    logic [3:0]  regAddr;
    logic [31:0] regWrData, regRdData, d;
    logic [15:0] sampleIn;
    logic [1:0]  sweepKind;
    cbq_point_t  pointOut;
    int          n_mismatch = 0, check_count = 0, rises = 0, falls = 0, sweeps = 0, r0, n0;
    cbq_row_t    rows[4] = '{'{32'h0000_0000, 32'h0000_0005, 32'h0000_03E8}, '{32'h0000_0000, 32'h0000_07D0,
                 32'h0000_07D0}, '{32'h0000_0040, 32'h0000_0000, 32'h0000_0001}, '{32'h0000_0040, 32'h0000_0003,
                 32'h0000_0003}};
    cbq_edge_t   ed[8] = '{'{CMD_CONT, 4'h1, 2'd3, 2'd0, 2'd0}, '{CMD_CONT, 4'h2, 2'd3, 2'd3, 2'd0},
                 '{CMD_EXTERNAL_TRIGGER_INPUT, 4'h8, 2'd1, 2'd3, 2'd0}, '{CMD_EXTERNAL_TRIGGER_INPUT, 4'h9, 2'd1, 2'd1, 2'd3},
                 '{CMD_EXTERNAL_TRIGGER_INPUT, 4'h4, 2'd1, 2'd3, 2'd3}, '{CMD_EXTERNAL_TRIGGER_INPUT, 4'h6, 2'd1, 2'd1, 2'd3},
                 '{CMD_EXTERNAL_TRIGGER_INPUT, 4'h2, 2'd1, 2'd1, 2'd3}, '{CMD_CONT_NOPAR, 4'h5, 2'd1, 2'd3, 2'd3}};

    cbq_sequencer dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .sampleIn(sampleIn), .externalTriggerInput(ext),
        .bufferPulse(bufferPulse), .sweepStart(sweepStart), .sweepRun(sweepRun), .sweepKind(sweepKind),
        .pointValid(pointValid), .pointReady(pointReady), .pointOut(pointOut));
    cbq_far_end #(.EDGE_GAP(40)) far (.mclk(mclk), .stall(stall), .pointValid(pointValid),
        .pointReady(pointReady), .pointOut(pointOut), .externalTriggerInput(ext));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (bufferPulse && !pulsePrev) rises <= rises + 1;
        if (!bufferPulse && pulsePrev) falls <= falls + 1;
        if (sweepStart) sweeps <= sweeps + 1;
        pulsePrev <= bufferPulse;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Gap cycle after each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 v = regRdData;
        @(posedge mclk);
    endtask

    task automatic wait_st(input logic [1:0] s);
        for (int i = 0; i < 600; i++) begin
            rd(REG_STATUS, d);
            if (d[1:0] === s) break;
        end
        chk(d[1:0], s);
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        rst = 1'b1; regAddr = 4'h0; regWrData = 32'h0000_0000; regWrite = 1'b0; regRead = 1'b0;
        sampleIn = 16'h5A5A; stall = 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        foreach (rows[i]) begin
            wr(REG_MODE, rows[i].mode);
            wr(REG_INTERVAL, rows[i].iv);
            rd(REG_INTERVAL, d); chk(d, rows[i].exp);
        end
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(REG_INTERVAL, d); chk(d, 32'h0000_03E8);
        rd(REG_LENGTH, d); chk(d, 32'h0000_0064);
        rd(REG_STATUS, d); chk(d[1:0], 2'b00);
        rd(4'hF, d); chk(d, 32'h0000_0000);
        // Per-point rising sample at standard interval: waiting on the interval would hang
        wr(REG_SWEEP, 32'h0000_0009);
        wr(REG_LENGTH, 32'h0000_0003);
        wr(REG_MODE, 32'h0000_0011);
        r0 = rises;
        wr(REG_CTRL, {29'h0, CMD_EXTERNAL_TRIGGER_INPUT});
        wr(REG_SWEEP, 32'h0000_0000);
        rd(REG_SWEEP, d); chk(d, 32'h0000_0009);
        chk(sweeps, 1);
        chk(sweepRun, 1'b1);
        chk(sweepKind, 2'b01);
        repeat (3) begin
            far.drive(1'b1);
            far.drive(1'b0);
        end
        wait_st(2'b00);
        chk(far.got.size(), 3);
        chk(rises - r0, 3);
        chk(sweepRun, 1'b0);
        // Falling sample, one pulse per curve, active low
        wr(REG_LENGTH, 32'h0000_0002);
        wr(REG_MODE, 32'h0000_0023);
        r0 = falls;
        wr(REG_CTRL, {29'h0, CMD_EXTERNAL_TRIGGER_INPUT});
        repeat (2) begin
            far.drive(1'b1);
            far.drive(1'b0);
        end
        wait_st(2'b00);
        chk(far.got.size(), 5);
        chk(falls - r0, 1);
        // Continuous at 1 us with the consumer stalled past the FIFO depth
        wr(REG_MODE, 32'h0000_0040);
        wr(REG_INTERVAL, 32'h0000_0001);
        n0 = far.got.size();
        sampleIn <= 16'hA5A5;
        stall <= 1'b1;
        wr(REG_CTRL, {29'h0, CMD_CONT});
        repeat (1500) @(posedge mclk);
        chk(pointValid, 1'b1);
        stall <= 1'b0;
        wr(REG_CTRL, {29'h0, CMD_HALT});
        wait_st(2'b00);
        repeat (8) @(posedge mclk);
        chk(far.got.size() - n0, 4);
        chk(sweeps, 2);
        wr(REG_LENGTH, 32'h0000_0100);
        foreach (ed[i]) begin
            wr(REG_MODE, {25'h0, 1'b1, 2'b00, ed[i].mode});
            wr(REG_CTRL, {29'h0, ed[i].cmd});
            rd(REG_STATUS, d); chk(d[1:0], ed[i].s0);
            far.drive(1'b1);
            rd(REG_STATUS, d); chk(d[1:0], ed[i].s1);
            far.drive(1'b0);
            rd(REG_STATUS, d); chk(d[1:0], ed[i].s2);
            wr(REG_CTRL, {29'h0, CMD_HALT});
            wait_st(2'b00);
        end
        rd(REG_MODE, d); chk(d[3:0], 4'h0);
        wr(REG_MODE, 32'h0000_0000);
        rd(REG_INTERVAL, d); chk(d, 32'h0000_03E8);
        // Every stored point continues from the current position
        for (int i = 1; i < far.got.size(); i++) begin
            chk(far.got[i].addr, 12'(far.got[i-1].addr + 12'h001));
            chk(far.got[i].data, (i < n0) ? 16'h5A5A : 16'hA5A5);
        end
        end_of_test();
    end
endmodule // curve_buffer_acquisition_sequencer_tb
